// *** verilog/lmec_map.svh ***
// Offsets, field positions, reset values and time bases of the effect control block.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef LMEC_MAP_SVH
`define LMEC_MAP_SVH

`define LMEC_OFF_DISP 8'h05
`define LMEC_OFF_AUDSYNC 8'h06
`define LMEC_OFF_FSTATE 8'h07
`define LMEC_OFF_FADE 8'h08
`define LMEC_OFF_BCTL 8'h09
`define LMEC_OFF_SD 8'h0A
`define LMEC_OFF_GAIN 8'h0B
`define LMEC_OFF_RATE 8'h0C

`define LMEC_MASK_DISP 8'h2F
`define LMEC_MASK_AUDSYNC 8'h01
`define LMEC_MASK_FADE 8'h77
`define LMEC_MASK_BCTL 8'h17
`define LMEC_MASK_SD 8'h03
`define LMEC_MASK_GAIN 8'h1F
`define LMEC_MASK_RATE 8'hFF
`define LMEC_RST_FUNC 8'h00

`define LMEC_SHARE_BIT 5
`define LMEC_BLINK_EN_BIT 3
`define LMEC_BLINK_PER_LSB 0
`define LMEC_AUDMOD_BIT 0
`define LMEC_INT_BIT 4
`define LMEC_FRAME_IDX_LSB 0
`define LMEC_FADE_OUT_LSB 4
`define LMEC_FADE_IN_LSB 0
`define LMEC_BEN_BIT 4
`define LMEC_EXT_LSB 0
`define LMEC_SD_NORMAL 2'h1
`define LMEC_GAIN_SPEED_BIT 4
`define LMEC_AUTO_GAIN_BIT 3
`define LMEC_GAIN_SEL_LSB 0

`define LMEC_CLK_NS 8
`define LMEC_BLINK_UNIT_NS 270000000
`define LMEC_FADE_UNIT_NS 26000000
`define LMEC_FADE_STEPS 32
`define LMEC_EXT_UNIT_NS 3500000
`define LMEC_SAMPLE_UNIT_NS 46000
`define LMEC_IRQ_HOLD_NS 9000000

`endif

// *** verilog/lmec_pkg.sv ***
// Types shared by the effect control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lmec_pkg;
	typedef enum logic [1:0] {LMEC_PICTURE, LMEC_AUTO_PLAY, LMEC_AUDIO_PLAY} lmec_mode_e;
	typedef enum logic [1:0] {LMEC_BR_IDLE, LMEC_BR_FADE_OUT, LMEC_BR_DARK, LMEC_BR_FADE_IN} lmec_breath_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lmec_host_req_s;
	typedef struct packed {
		logic modulation_on;
		logic auto_gain_on;
		logic gain_tracking_speed;
		logic [2:0] audio_gain_select;
	} lmec_audio_cfg_s;
endpackage
`default_nettype wire

// *** verilog/lmec_tick.sv ***
// Prescaler giving a one-cycle enable strobe every DIV cycles.
// Assumes a single core clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module lmec_tick #(
	parameter int unsigned DIV = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	output logic tick
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q + 32'h0000_0001;
		if (cnt_q >= 32'(DIV - 1)) begin
			cnt_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cnt_q <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = (cnt_q >= 32'(DIV - 1));
endmodule
`default_nettype wire

// *** verilog/lmec_effect_ctrl.sv ***
// Function registers and effect timing of a 144-LED matrix driver.
// Assumes a serial-bus engine delivering one-cycle read/write strobes and a scan engine feeding one LED at a time.
`timescale 1ns/100ps
`default_nettype none
`include "lmec_map.svh"
module lmec_effect_ctrl import lmec_pkg::*; #(
	parameter int unsigned BLINK_HALF_CYC = `LMEC_BLINK_UNIT_NS / 2 / `LMEC_CLK_NS,
	parameter int unsigned FADE_STEP_CYC = `LMEC_FADE_UNIT_NS / `LMEC_FADE_STEPS / `LMEC_CLK_NS,
	parameter int unsigned EXT_UNIT_CYC = `LMEC_EXT_UNIT_NS / `LMEC_CLK_NS,
	parameter int unsigned SAMPLE_UNIT_CYC = `LMEC_SAMPLE_UNIT_NS / `LMEC_CLK_NS,
	parameter int unsigned IRQ_HOLD_CYC = `LMEC_IRQ_HOLD_NS / `LMEC_CLK_NS
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire lmec_host_req_s host_req,
	output logic [7:0] reg_rdata,
	input wire lmec_mode_e play_mode,
	input wire logic movie_end,
	input wire logic frame_switch,
	input wire logic [2:0] shown_frame_index,
	input wire logic [7:0] global_current_scale,
	input wire logic [7:0] audio_level,
	input wire logic [7:0] led_pwm,
	input wire logic led_blink_bit,
	input wire logic frame_wr_req,
	output logic frame_wr_ok,
	output logic [2:0] intensity_frame,
	output logic audio_sample_stb,
	output lmec_audio_cfg_s audio_cfg,
	output logic breath_busy,
	output logic leds_blanked,
	output logic movie_done_irq_n,
	output logic led_drive
);
	logic [7:0] disp_q, disp_d, audsync_q, audsync_d, fade_q, fade_d, bctl_q, bctl_d;
	logic [7:0] sd_q, sd_d, agc_q, agc_d, rate_q, rate_d, rdata_q, rdata_d;
	logic done_q, done_d, irq_n_q, irq_n_d;
	logic [31:0] irq_cnt_q, irq_cnt_d;
	logic [3:0] bcnt_q, bcnt_d;
	logic dark_q, dark_d;
	lmec_breath_e bst_q, bst_d;
	logic [7:0] step_q, step_d;
	logic [4:0] lvl_q, lvl_d;
	logic [8:0] acnt_q, acnt_d;
	logic [7:0] alvl_q, alvl_d;
	logic stb_q, stb_d;
	logic [7:0] pcnt_q, pcnt_d;
	logic drive_q, drive_d;
	logic blink_tick, fade_tick, ext_tick, sample_tick;
	logic fs_read, done_set, audio_mode, sampling;
	logic [2:0] blink_period;
	logic [8:0] rate_n;
	logic [7:0] fade_lim, ext_lim, fade_lvl, inten, eff;
	logic [15:0] prod_a, prod_b, prod_c;

	// Effect time bases
	lmec_tick #(.DIV(BLINK_HALF_CYC)) u_blink_tick (.core_clk(core_clk), .resetn(resetn), .tick(blink_tick));
	lmec_tick #(.DIV(FADE_STEP_CYC)) u_fade_tick (.core_clk(core_clk), .resetn(resetn), .tick(fade_tick));
	lmec_tick #(.DIV(EXT_UNIT_CYC)) u_ext_tick (.core_clk(core_clk), .resetn(resetn), .tick(ext_tick));
	lmec_tick #(.DIV(SAMPLE_UNIT_CYC)) u_sample_tick (.core_clk(core_clk), .resetn(resetn), .tick(sample_tick));

	assign fs_read = host_req.rd && (host_req.addr == `LMEC_OFF_FSTATE);
	assign done_set = movie_end && (play_mode == LMEC_AUTO_PLAY);
	assign audio_mode = (play_mode == LMEC_AUDIO_PLAY);

	// Register file and status
	always_comb begin
		disp_d = disp_q;
		audsync_d = audsync_q;
		fade_d = fade_q;
		bctl_d = bctl_q;
		sd_d = sd_q;
		agc_d = agc_q;
		rate_d = rate_q;
		rdata_d = rdata_q;
		if (host_req.wr) begin
			case (host_req.addr)
				`LMEC_OFF_DISP: disp_d = host_req.wdata & `LMEC_MASK_DISP;
				`LMEC_OFF_AUDSYNC: audsync_d = host_req.wdata & `LMEC_MASK_AUDSYNC;
				`LMEC_OFF_FADE: fade_d = host_req.wdata & `LMEC_MASK_FADE;
				`LMEC_OFF_BCTL: bctl_d = host_req.wdata & `LMEC_MASK_BCTL;
				`LMEC_OFF_SD: sd_d = host_req.wdata & `LMEC_MASK_SD;
				`LMEC_OFF_GAIN: agc_d = host_req.wdata & `LMEC_MASK_GAIN;
				`LMEC_OFF_RATE: rate_d = host_req.wdata & `LMEC_MASK_RATE;
				default: ;
			endcase
		end
		if (host_req.rd) begin
			case (host_req.addr)
				`LMEC_OFF_DISP: rdata_d = disp_q;
				`LMEC_OFF_AUDSYNC: rdata_d = audsync_q;
				`LMEC_OFF_FSTATE: rdata_d = {3'h0, done_q, 1'b0, shown_frame_index};
				`LMEC_OFF_FADE: rdata_d = fade_q;
				`LMEC_OFF_BCTL: rdata_d = bctl_q;
				`LMEC_OFF_SD: rdata_d = sd_q;
				`LMEC_OFF_GAIN: rdata_d = agc_q;
				`LMEC_OFF_RATE: rdata_d = rate_q;
				default: rdata_d = 8'h00;
			endcase
		end
		done_d = done_set || (done_q && !fs_read);
		irq_n_d = irq_n_q;
		irq_cnt_d = irq_cnt_q;
		if (!irq_n_q) begin
			irq_cnt_d = irq_cnt_q + 32'h0000_0001;
			if (fs_read || irq_cnt_q >= 32'(IRQ_HOLD_CYC - 1)) begin
				irq_n_d = 1'b1;
			end
		end
		if (done_set) begin
			irq_n_d = 1'b0;
			irq_cnt_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			disp_q <= `LMEC_RST_FUNC;
			audsync_q <= `LMEC_RST_FUNC;
			fade_q <= `LMEC_RST_FUNC;
			bctl_q <= `LMEC_RST_FUNC;
			sd_q <= `LMEC_RST_FUNC;
			agc_q <= `LMEC_RST_FUNC;
			rate_q <= `LMEC_RST_FUNC;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
			irq_n_q <= 1'b1;
			irq_cnt_q <= 32'h0000_0000;
		end else begin
			disp_q <= disp_d;
			audsync_q <= audsync_d;
			fade_q <= fade_d;
			bctl_q <= bctl_d;
			sd_q <= sd_d;
			agc_q <= agc_d;
			rate_q <= rate_d;
			rdata_q <= rdata_d;
			done_q <= done_d;
			irq_n_q <= irq_n_d;
			irq_cnt_q <= irq_cnt_d;
		end
	end

	assign blink_period = disp_q[`LMEC_BLINK_PER_LSB +: 3];
	assign fade_lim = (bst_q == LMEC_BR_FADE_OUT) ? (8'h01 << fade_q[`LMEC_FADE_OUT_LSB +: 3]) - 8'h01
		: (8'h01 << fade_q[`LMEC_FADE_IN_LSB +: 3]) - 8'h01;
	assign ext_lim = (8'h01 << bctl_q[`LMEC_EXT_LSB +: 3]) - 8'h01;
	assign rate_n = (rate_q == 8'h00) ? 9'h100 : {1'b0, rate_q};
	assign sampling = audio_mode || audsync_q[`LMEC_AUDMOD_BIT];

	// Blink, breath and audio sampling timing
	always_comb begin
		bcnt_d = bcnt_q;
		dark_d = dark_q;
		if (!disp_q[`LMEC_BLINK_EN_BIT] || blink_period == 3'h0) begin
			bcnt_d = 4'h0;
			dark_d = 1'b0;
		end else if (blink_tick) begin
			bcnt_d = bcnt_q + 4'h1;
			if (bcnt_q >= {1'b0, blink_period} - 4'h1) begin
				bcnt_d = 4'h0;
				dark_d = !dark_q;
			end
		end
		bst_d = bst_q;
		step_d = step_q;
		lvl_d = lvl_q;
		case (bst_q)
			LMEC_BR_IDLE: begin
				lvl_d = 5'h1F;
				step_d = 8'h00;
				if (frame_switch && bctl_q[`LMEC_BEN_BIT] && !audio_mode) begin
					bst_d = LMEC_BR_FADE_OUT;
				end
			end
			LMEC_BR_FADE_OUT: begin
				if (fade_tick) begin
					step_d = step_q + 8'h01;
					if (step_q >= fade_lim) begin
						step_d = 8'h00;
						lvl_d = lvl_q - 5'h01;
						if (lvl_q == 5'h01) begin
							bst_d = LMEC_BR_DARK;
						end
					end
				end
			end
			LMEC_BR_DARK: begin
				if (ext_tick) begin
					step_d = step_q + 8'h01;
					if (step_q >= ext_lim) begin
						step_d = 8'h00;
						bst_d = LMEC_BR_FADE_IN;
					end
				end
			end
			LMEC_BR_FADE_IN: begin
				if (fade_tick) begin
					step_d = step_q + 8'h01;
					if (step_q >= fade_lim) begin
						step_d = 8'h00;
						lvl_d = lvl_q + 5'h01;
						if (lvl_q == 5'h1E) begin
							bst_d = LMEC_BR_IDLE;
						end
					end
				end
			end
			default: bst_d = LMEC_BR_IDLE;
		endcase
		acnt_d = acnt_q;
		alvl_d = alvl_q;
		stb_d = 1'b0;
		if (!sampling) begin
			acnt_d = 9'h000;
		end else if (sample_tick) begin
			acnt_d = acnt_q + 9'h001;
			if (acnt_q >= rate_n - 9'h001) begin
				acnt_d = 9'h000;
				stb_d = 1'b1;
				alvl_d = audio_level;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bcnt_q <= 4'h0;
			dark_q <= 1'b0;
			bst_q <= LMEC_BR_IDLE;
			step_q <= 8'h00;
			lvl_q <= 5'h1F;
			acnt_q <= 9'h000;
			alvl_q <= 8'h00;
			stb_q <= 1'b0;
		end else begin
			bcnt_q <= bcnt_d;
			dark_q <= dark_d;
			bst_q <= bst_d;
			step_q <= step_d;
			lvl_q <= lvl_d;
			acnt_q <= acnt_d;
			alvl_q <= alvl_d;
			stb_q <= stb_d;
		end
	end

	// LED drive: PWM, global scale, audio and fade
	assign fade_lvl = {lvl_q, lvl_q[4:2]};
	assign prod_a = led_pwm * global_current_scale;
	assign prod_b = (audsync_q[`LMEC_AUDMOD_BIT] ? alvl_q : 8'hFF) * fade_lvl;
	assign inten = prod_b[15:8];
	assign prod_c = prod_a[15:8] * inten;
	assign eff = prod_c[15:8];

	always_comb begin
		pcnt_d = pcnt_q + 8'h01;
		drive_d = (pcnt_q < eff);
		if (sd_q[1:0] != `LMEC_SD_NORMAL) begin
			drive_d = 1'b0;
		end
		if (disp_q[`LMEC_BLINK_EN_BIT] && led_blink_bit && dark_q) begin
			drive_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pcnt_q <= 8'h00;
			drive_q <= 1'b0;
		end else begin
			pcnt_q <= pcnt_d;
			drive_q <= drive_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign frame_wr_ok = frame_wr_req && !sd_q[1];
	assign intensity_frame = disp_q[`LMEC_SHARE_BIT] ? 3'h0 : shown_frame_index;
	assign audio_sample_stb = stb_q;
	assign audio_cfg.modulation_on = audsync_q[`LMEC_AUDMOD_BIT];
	assign audio_cfg.auto_gain_on = agc_q[`LMEC_AUTO_GAIN_BIT];
	assign audio_cfg.gain_tracking_speed = agc_q[`LMEC_GAIN_SPEED_BIT];
	assign audio_cfg.audio_gain_select = sampling ? agc_q[`LMEC_GAIN_SEL_LSB +: 3] : 3'h0;
	assign breath_busy = (bst_q != LMEC_BR_IDLE);
	assign leds_blanked = (sd_q[1:0] != `LMEC_SD_NORMAL);
	assign movie_done_irq_n = irq_n_q;
	assign led_drive = drive_q;

	AST_SHARED_INTENSITY:
	assert property (@(posedge core_clk) disable iff (!resetn) disp_q[`LMEC_SHARE_BIT] |-> intensity_frame == 3'h0)
		else $error("shared intensity not frame one");
	AST_BLINK_OFF_STEADY:
	assert property (@(posedge core_clk) disable iff (!resetn) !disp_q[`LMEC_BLINK_EN_BIT] |=> !dark_q)
		else $error("blink phase moved while disabled");
	AST_FSTATE_READ:
	assert property (@(posedge core_clk) disable iff (!resetn)
		fs_read |=> reg_rdata == {3'h0, $past(done_q), 1'b0, $past(shown_frame_index)})
		else $error("frame state read wrong");
	AST_DONE_SET:
	assert property (@(posedge core_clk) disable iff (!resetn) done_set |=> done_q && !movie_done_irq_n)
		else $error("movie end not flagged");
	AST_DONE_HOLD:
	assert property (@(posedge core_clk) disable iff (!resetn) done_q && !fs_read |=> done_q)
		else $error("done flag lost without read");
	AST_DONE_CLEAR:
	assert property (@(posedge core_clk) disable iff (!resetn) fs_read && !done_set |=> !done_q)
		else $error("done flag not cleared by read");
	AST_BREATH_GATE:
	assert property (@(posedge core_clk) disable iff (!resetn)
		bst_q == LMEC_BR_IDLE && (audio_mode || !bctl_q[`LMEC_BEN_BIT]) |=> bst_q == LMEC_BR_IDLE)
		else $error("breath started when not allowed");
	AST_BLANKED:
	assert property (@(posedge core_clk) disable iff (!resetn) sd_q[1:0] != `LMEC_SD_NORMAL |=> !led_drive)
		else $error("LED driven in shutdown");
	AST_SD1_ACCESS:
	assert property (@(posedge core_clk) disable iff (!resetn) sd_q[1:0] == 2'h0 && frame_wr_req |-> frame_wr_ok)
		else $error("frame write refused in shutdown one");
	AST_SD2_REFUSE:
	assert property (@(posedge core_clk) disable iff (!resetn) sd_q[1] |-> !frame_wr_ok)
		else $error("frame write taken in shutdown two");
	AST_IRQ_RELEASE:
	assert property (@(posedge core_clk) disable iff (!resetn)
		!movie_done_irq_n && fs_read && !done_set |=> movie_done_irq_n)
		else $error("interrupt not released by read");
endmodule
`default_nettype wire

// *** tb/lmec_host_model.sv ***
// Host side of the register access strobes for the effect control block.
// Assumes one-cycle wr/rd strobes and read data valid one edge after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module lmec_host_model import lmec_pkg::*; (
	input wire logic core_clk,
	output lmec_host_req_s host_req,
	input wire logic [7:0] reg_rdata
);
	initial host_req = '0;

	// Single byte write, released bus shows inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
	endtask

	// Single byte read, data taken after the answering edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge core_clk);
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		#1;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// *** tb/test_led_matrix_effect_control.sv ***
// Self-checking bench for the effect control block.
// Assumes small time-base parameters so effect timing fits a short run.
`timescale 1ns/100ps
`default_nettype none
`include "lmec_map.svh"
module test_led_matrix_effect_control import lmec_pkg::*; ;
	localparam int U = 4;
	localparam int IRQ = 16;
	logic core_clk, resetn, movie_end, frame_switch, led_blink_bit, frame_wr_req, frame_wr_ok;
	logic audio_sample_stb, breath_busy, leds_blanked, movie_done_irq_n, led_drive;
	lmec_host_req_s host_req;
	lmec_mode_e play_mode;
	lmec_audio_cfg_s audio_cfg;
	logic [7:0] reg_rdata, global_current_scale, audio_level, led_pwm, rv;
	logic [2:0] shown_frame_index, intensity_frame;
	logic [7:0] msk [8] = '{8'h2F, 8'h01, 8'h05, 8'h77, 8'h17, 8'h03, 8'h1F, 8'hFF};
	logic [7:0] gam [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0A, 8'h0D, 8'h12};
	int err_total, n_compared, cyc, n0, n1, n2, base, x, prev;

	lmec_effect_ctrl #(.BLINK_HALF_CYC(U), .FADE_STEP_CYC(U), .EXT_UNIT_CYC(U), .SAMPLE_UNIT_CYC(U),
		.IRQ_HOLD_CYC(IRQ)) dut (.core_clk, .resetn, .host_req, .reg_rdata, .play_mode, .movie_end,
		.frame_switch, .shown_frame_index, .global_current_scale, .audio_level, .led_pwm, .led_blink_bit,
		.frame_wr_req, .frame_wr_ok, .intensity_frame, .audio_sample_stb, .audio_cfg, .breath_busy,
		.leds_blanked, .movie_done_irq_n, .led_drive);
	lmec_host_model host (.core_clk, .host_req, .reg_rdata);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic give_verdict();
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rdc(logic [7:0] a, logic [7:0] exp, string nm);
		host.rd(a, rv);
		check(nm, rv, exp);
	endtask

	task automatic count_on(int n, output int ones);
		ones = 0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (led_drive === 1'b1) ones++;
		end
	endtask

	task automatic next_stb(output int g);
		g = 0;
		do begin
			@(posedge core_clk);
			#1;
			g++;
		end while (audio_sample_stb !== 1'b1 && g < 3000);
	endtask

	task automatic breath_len(output int n);
		n = 0;
		@(posedge core_clk);
		#1;
		while (cyc % U != 0) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk) frame_switch <= 1'b1;
		@(posedge core_clk) frame_switch <= 1'b0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (breath_busy === 1'b1 && n < 3000);
	endtask

	task automatic movie_strobe();
		@(posedge core_clk) movie_end <= 1'b1;
		@(posedge core_clk) movie_end <= 1'b0;
		#1;
	endtask

	initial begin
		{resetn, movie_end, frame_switch, led_blink_bit, audio_level} = '0;
		{err_total, n_compared, cyc} = '0;
		play_mode = LMEC_PICTURE;
		shown_frame_index = 3'h5;
		global_current_scale = 8'hFF;
		led_pwm = 8'hFF;
		frame_wr_req = 1'b1;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		for (int a = 5; a <= 13; a++) rdc(8'(a), (a == 7) ? 8'h05 : 8'h00, "reset value");
		for (int a = 5; a <= 12; a++) host.wr(8'(a), 8'hFF);
		for (int a = 5; a <= 12; a++) rdc(8'(a), msk[a - 5], "stored bits");
		for (int a = 5; a <= 12; a++) host.wr(8'(a), 8'h00);
		check("intensity_frame", intensity_frame, 3'h5);
		host.wr(`LMEC_OFF_DISP, 8'h20);
		check("intensity_frame", intensity_frame, 3'h0);
		host.wr(`LMEC_OFF_DISP, 8'h00);
		frame_wr_req <= 1'b0;
		#1;
		check("frame_wr_ok idle", frame_wr_ok, 0);
		frame_wr_req <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			host.wr(`LMEC_OFF_SD, 8'(s));
			check("leds_blanked", leds_blanked, s != 1);
			check("frame_wr_ok", frame_wr_ok, s < 2);
			rdc(`LMEC_OFF_SD, 8'(s), "shutdown field");
		end
		host.wr(`LMEC_OFF_SD, 8'h01);
		movie_strobe();
		check("irq picture", movie_done_irq_n, 1);
		rdc(`LMEC_OFF_FSTATE, 8'h05, "done picture");
		play_mode <= LMEC_AUTO_PLAY;
		movie_strobe();
		check("irq set", movie_done_irq_n, 0);
		rdc(`LMEC_OFF_FSTATE, 8'h15, "done set");
		check("irq read", movie_done_irq_n, 1);
		rdc(`LMEC_OFF_FSTATE, 8'h05, "done cleared");
		movie_strobe();
		repeat (IRQ - 1) @(posedge core_clk);
		#1;
		check("irq hold", movie_done_irq_n, 0);
		@(posedge core_clk);
		#1;
		check("irq release", movie_done_irq_n, 1);
		rdc(`LMEC_OFF_FSTATE, 8'h15, "done kept");
		play_mode <= LMEC_PICTURE;
		host.wr(`LMEC_OFF_GAIN, 8'h1F);
		check("cfg picture", audio_cfg, 6'h18);
		play_mode <= LMEC_AUDIO_PLAY;
		for (int g = 0; g < 8; g++) begin
			host.wr(`LMEC_OFF_GAIN, 8'h10 | 8'(g));
			check("cfg audio", audio_cfg, 6'h08 | 6'(g));
		end
		host.wr(`LMEC_OFF_RATE, 8'h03);
		next_stb(x);
		next_stb(x);
		check("sample gap", x, 3 * U);
		host.wr(`LMEC_OFF_RATE, 8'h00);
		next_stb(x);
		next_stb(x);
		check("sample gap zero", x, 256 * U);
		host.wr(`LMEC_OFF_BCTL, 8'h10);
		breath_len(x);
		check("breath audio", x, 1);
		play_mode <= LMEC_PICTURE;
		host.wr(`LMEC_OFF_AUDSYNC, 8'h01);
		check("cfg modulation", audio_cfg, 6'h2F);
		host.wr(`LMEC_OFF_AUDSYNC, 8'h00);
		breath_len(n0);
		host.wr(`LMEC_OFF_BCTL, 8'h12);
		breath_len(n2);
		check("extinguish", n2 - n0, 3 * U);
		host.wr(`LMEC_OFF_BCTL, 8'h10);
		host.wr(`LMEC_OFF_FADE, 8'h10);
		breath_len(n1);
		check("fade out", n1 - n0, 31 * U);
		host.wr(`LMEC_OFF_FADE, 8'h01);
		breath_len(n1);
		check("fade in", n1 - n0, 31 * U);
		count_on(512, base);
		check("steady drive", base > 400, 1);
		host.wr(`LMEC_OFF_DISP, 8'h09);
		led_blink_bit <= 1'b1;
		count_on(512, x);
		check("blink duty", x > base / 4 && x < base * 3 / 4, 1);
		led_blink_bit <= 1'b0;
		count_on(512, x);
		check("no blink", x, base);
		global_current_scale <= 8'h00;
		count_on(256, x);
		check("gcc zero", x, 0);
		global_current_scale <= 8'hFF;
		prev = 0;
		foreach (gam[i]) begin
			led_pwm <= gam[i];
			count_on(256, x);
			check("gamma ramp", x >= prev, 1);
			prev = x;
		end
		led_pwm <= 8'h00;
		count_on(256, x);
		check("pwm zero", x, 0);
		led_pwm <= 8'hFF;
		audio_level <= 8'h80;
		host.wr(`LMEC_OFF_RATE, 8'h01);
		host.wr(`LMEC_OFF_AUDSYNC, 8'h01);
		next_stb(x);
		count_on(256, x);
		check("audio scaled", x, 126);
		host.wr(`LMEC_OFF_SD, 8'h00);
		count_on(256, x);
		check("shutdown dark", x, 0);
		give_verdict();
	end
endmodule
`default_nettype wire
